// [logic/sensor_cmd_pkg.sv]
// constants and carrier types for the single-wire sensor command layer
package sensor_cmd_pkg;

    // selection (identity-level) command codes
    localparam logic [7:0] CMD_SEARCH_ID  = 8'hf0;
    localparam logic [7:0] CMD_READ_ID    = 8'h33;
    localparam logic [7:0] CMD_MATCH_ID   = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID    = 8'hcc;
    localparam logic [7:0] CMD_ALARM_SRCH = 8'hec;

    // function command codes
    localparam logic [7:0] CMD_CONVERT    = 8'h44;
    localparam logic [7:0] CMD_WRITE_SP   = 8'h4e;
    localparam logic [7:0] CMD_READ_SP    = 8'hbe;
    localparam logic [7:0] CMD_COPY_SP    = 8'h48;
    localparam logic [7:0] CMD_RELOAD     = 8'hb8;

    // scratchpad byte offsets
    localparam int SP_TEMP_OFS  = 0;
    localparam int SP_TH_OFS    = 2;
    localparam int SP_TL_OFS    = 3;
    localparam int SP_CFG_OFS   = 4;
    localparam int SP_CRC_OFS   = 8;
    localparam int SP_BYTES     = 9;

    // field positions and sizes
    localparam int CFG_RES_LSB  = 5;
    localparam int ID_BITS      = 64;
    localparam int CMD_BITS     = 8;
    localparam int WR_SP_BITS   = 24;
    localparam int SP_BITS      = SP_BYTES * 8;

    // fixed read values of reserved scratchpad content
    localparam logic [7:0] SP_RSVD_BYTE = 8'hff;
    localparam logic [7:0] CFG_FIXED    = 8'h1f;

    // values after reset
    localparam logic [15:0] TEMP_RST    = 16'h0000;
    localparam logic [7:0]  TH_RST      = 8'h00;
    localparam logic [7:0]  TL_RST      = 8'h00;
    localparam logic [1:0]  RES_RST     = 2'h3;

    // crc x^8+x^5+x^4+1, bit-reversed for lsb-first shifting
    localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
    localparam logic [7:0] CRC_INIT      = 8'h00;

    // line-low reset time
    localparam int CLK_MHZ        = 250;
    localparam int LINE_RESET_US  = 480;
    localparam int LINE_RESET_CYC = LINE_RESET_US * CLK_MHZ;

    // thresholds and configuration moved to/from nonvolatile storage
    typedef struct packed {
        logic [7:0] th;
        logic [7:0] tl;
        logic [1:0] res;
    } nv_bytes_t;

    // result handed over by the converter
    typedef struct packed {
        logic [15:0] temp;
        logic        alarm;
    } conv_result_t;

endpackage

// [logic/crc8_calc.sv]
// combinational lsb-first crc over a vector
module crc8_calc #(
    parameter int BITS = 64
) (
    input  wire logic [BITS-1:0] data,
    output logic      [7:0]      crc
);
    import sensor_cmd_pkg::*;

    always_comb begin
        logic fb;
        fb  = 1'b0;
        crc = CRC_INIT;
        for (int i = 0; i < BITS; i++) begin
            fb  = crc[0] ^ data[i];
            crc = {1'b0, crc[7:1]};
            if (fb) begin
                crc = crc ^ CRC_POLY_REFL;
            end
        end
    end
endmodule

// [logic/line_low_detect.sv]
// synchronises the line and flags a low longer than the reset time
module line_low_detect #(
    parameter int LOW_CYC = 120000
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic dq_in,
    output logic      long_low
);
    import sensor_cmd_pkg::*;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic [17:0] cnt;
        logic        fired;
    } det_t;

    localparam det_t DET_RST = '{s1: 1'b1, s2: 1'b1, cnt: '0, fired: 1'b0};

    det_t s_q;
    det_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.s1    = dq_in;
        s_d.s2    = s_q.s1;
        s_d.fired = 1'b0;
        if (s_q.s2) begin
            s_d.cnt = '0;
        end else if (s_q.cnt != 18'(LOW_CYC)) begin
            s_d.cnt = s_q.cnt + 18'h1;
            // one pulse when the low outlasts the reset time
            s_d.fired = (s_q.cnt == 18'(LOW_CYC - 1));
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= DET_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign long_low = s_q.fired;
endmodule

// [logic/sensor_cmd_layer.sv]
// command and transaction layer of the single-wire temperature sensor
// Notes on behaviour
// - reset, selection, function; otherwise stay silent
// - after either search, wait for reset
// - reset pulse starts transaction; presence answered below
// - decode five 8-bit selection commands
// - identity search takes part in elimination
// - read-identity sends all 64 id bits
// - match needs exact 64-bit match, else halt
// - skip selection addresses device without id
// - alarm search joins only with alarm set
// - convert starts conversion, stores two-byte result
// - write stores three bytes into 2,3,4
// - read sends bytes 0 to 8 lsb first
// - reset stops a scratchpad read anytime
// - copy sends bytes 2 to 4 to storage
// - reload refills 2-4; reads show 0/1 status
// - reload runs by itself after power-up
// - all bytes travel lsb first
// - crc over bytes 0-7, x^8+x^5+x^4+1
// - line low past 480 us resets sequence
module sensor_cmd_layer
    import sensor_cmd_pkg::*;
#(
    parameter int LINE_LOW_CYC = sensor_cmd_pkg::LINE_RESET_CYC
) (
    input  wire logic                        MCLK,
    input  wire logic                        RST_B,
    input  wire logic                        CE,
    input  wire logic                        DQ_IN,
    input  wire logic                        SLOT_RESET,
    input  wire logic                        WR_BIT_VLD,
    input  wire logic                        WR_BIT,
    input  wire logic                        RD_SLOT,
    output logic                             RD_BIT,
    input  wire logic [63:0]                 ROM_ID,
    output logic                             CONV_START,
    output logic [1:0]                       CONV_RES,
    input  wire logic                        CONV_DONE,
    input  wire sensor_cmd_pkg::conv_result_t CONV_RESULT,
    output logic                             NV_COPY_REQ,
    output sensor_cmd_pkg::nv_bytes_t        NV_WR_DATA,
    input  wire logic                        NV_COPY_DONE,
    output logic                             NV_RELOAD_REQ,
    input  wire logic                        NV_RELOAD_DONE,
    input  wire sensor_cmd_pkg::nv_bytes_t   NV_RD_DATA,
    output logic                             BUSY
);
    import sensor_cmd_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ROM_CMD,
        S_SEARCH,
        S_READ_ID,
        S_MATCH,
        S_FUNC_CMD,
        S_WRITE_SP,
        S_READ_SP,
        S_RELOAD_STAT,
        S_HALT
    } phase_t;

    typedef struct packed {
        phase_t      st;
        logic [6:0]  idx;
        logic [1:0]  sub;
        logic [7:0]  sh;
        logic [15:0] temp;
        logic [7:0]  th;
        logic [7:0]  tl;
        logic [1:0]  res;
        logic        alarm;
        logic        conv_busy;
        logic        copy_busy;
        logic        reload_busy;
        logic        pwrup_done;
        logic        rd_bit;
        logic        conv_start;
        logic        copy_req;
        logic        reload_req;
        logic        busy;
    } state_t;

    localparam state_t ST_RST = '{
        st: S_IDLE, idx: '0, sub: '0, sh: '0, temp: TEMP_RST,
        th: TH_RST, tl: TL_RST, res: RES_RST, alarm: 1'b0,
        conv_busy: 1'b0, copy_busy: 1'b0, reload_busy: 1'b0,
        pwrup_done: 1'b0, rd_bit: 1'b1, conv_start: 1'b0,
        copy_req: 1'b0, reload_req: 1'b0, busy: 1'b0
    };

    state_t       s_q;
    state_t       s_d;
    logic         long_low;
    logic [63:0]  sp_body;
    logic [7:0]   sp_crc;
    logic [71:0]  sp_next;
    logic [7:0]   cmd_byte;
    logic [7:0]   cfg_byte;
    logic         id_bit;

    line_low_detect #(
        .LOW_CYC (LINE_LOW_CYC)
    ) u_low (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .ce       (CE),
        .dq_in    (DQ_IN),
        .long_low (long_low)
    );

    // scratchpad image from registered values, no loop through s_d
    always_comb begin
        cfg_byte = CFG_FIXED;
        cfg_byte[CFG_RES_LSB +: 2] = s_q.res;
        sp_body  = {SP_RSVD_BYTE, SP_RSVD_BYTE, SP_RSVD_BYTE, cfg_byte,
                    s_q.tl, s_q.th, s_q.temp};
        sp_next  = {sp_crc, sp_body};
    end

    crc8_calc #(
        .BITS (64)
    ) u_crc (
        .data (sp_body),
        .crc  (sp_crc)
    );

    // byte completing with the current write slot, lsb first
    assign cmd_byte = {WR_BIT, s_q.sh[7:1]};
    assign id_bit   = ROM_ID[s_q.idx[5:0]];

    always_comb begin
        s_d            = s_q;
        s_d.conv_start = 1'b0;
        s_d.copy_req   = 1'b0;
        s_d.reload_req = 1'b0;

        if (CONV_DONE) begin
            s_d.temp      = CONV_RESULT.temp;
            s_d.alarm     = CONV_RESULT.alarm;
            s_d.conv_busy = 1'b0;
        end
        if (NV_COPY_DONE) begin
            s_d.copy_busy = 1'b0;
        end
        // reload lands in bytes 2 to 4
        if (NV_RELOAD_DONE) begin
            s_d.th          = NV_RD_DATA.th;
            s_d.tl          = NV_RD_DATA.tl;
            s_d.res         = NV_RD_DATA.res;
            s_d.reload_busy = 1'b0;
        end
        if (!s_q.pwrup_done) begin
            s_d.pwrup_done  = 1'b1;
            s_d.reload_req  = 1'b1;
            s_d.reload_busy = 1'b1;
        end

        case (s_q.st)
            S_ROM_CMD: begin
                if (WR_BIT_VLD) begin
                    s_d.sh  = cmd_byte;
                    s_d.idx = s_q.idx + 7'h1;
                    if (s_q.idx == 7'(CMD_BITS - 1)) begin
                        s_d.idx = '0;
                        s_d.sub = '0;
                        case (cmd_byte)
                            CMD_SEARCH_ID:  s_d.st = S_SEARCH;
                            CMD_ALARM_SRCH: begin
                                s_d.st = s_q.alarm ? S_SEARCH : S_HALT;
                            end
                            CMD_READ_ID:    s_d.st = S_READ_ID;
                            CMD_MATCH_ID:   s_d.st = S_MATCH;
                            CMD_SKIP_ID:    s_d.st = S_FUNC_CMD;
                            default:        s_d.st = S_HALT;
                        endcase
                    end
                end
            end
            S_SEARCH: begin
                if (RD_SLOT && s_q.sub != 2'h2) begin
                    s_d.sub = s_q.sub + 2'h1;
                end else if (WR_BIT_VLD && s_q.sub == 2'h2) begin
                    s_d.sub = '0;
                    s_d.idx = s_q.idx + 7'h1;
                    if (WR_BIT != id_bit) begin
                        s_d.st = S_HALT;
                    end else if (s_q.idx == 7'(ID_BITS - 1)) begin
                        s_d.st = S_HALT;
                    end
                end
            end
            S_READ_ID: begin
                if (RD_SLOT) begin
                    s_d.idx = s_q.idx + 7'h1;
                    if (s_q.idx == 7'(ID_BITS - 1)) begin
                        s_d.idx = '0;
                        s_d.st  = S_FUNC_CMD;
                    end
                end
            end
            S_MATCH: begin
                if (WR_BIT_VLD) begin
                    s_d.idx = s_q.idx + 7'h1;
                    if (WR_BIT != id_bit) begin
                        s_d.st = S_HALT;
                    end else if (s_q.idx == 7'(ID_BITS - 1)) begin
                        s_d.idx = '0;
                        s_d.st  = S_FUNC_CMD;
                    end
                end
            end
            S_FUNC_CMD: begin
                if (WR_BIT_VLD) begin
                    s_d.sh  = cmd_byte;
                    s_d.idx = s_q.idx + 7'h1;
                    if (s_q.idx == 7'(CMD_BITS - 1)) begin
                        s_d.idx = '0;
                        s_d.st  = S_HALT;
                        case (cmd_byte)
                            CMD_CONVERT: begin
                                s_d.conv_start = 1'b1;
                                s_d.conv_busy  = 1'b1;
                            end
                            CMD_WRITE_SP: s_d.st = S_WRITE_SP;
                            CMD_READ_SP:  s_d.st = S_READ_SP;
                            CMD_COPY_SP: begin
                                s_d.copy_req  = 1'b1;
                                s_d.copy_busy = 1'b1;
                            end
                            CMD_RELOAD: begin
                                s_d.reload_req  = 1'b1;
                                s_d.reload_busy = 1'b1;
                                s_d.st          = S_RELOAD_STAT;
                            end
                            default: s_d.st = S_HALT;
                        endcase
                    end
                end
            end
            // three bytes into th, tl, configuration
            S_WRITE_SP: begin
                if (WR_BIT_VLD) begin
                    s_d.sh  = cmd_byte;
                    s_d.idx = s_q.idx + 7'h1;
                    if (s_q.idx[2:0] == 3'h7) begin
                        case (s_q.idx[4:3])
                            2'h0:    s_d.th  = cmd_byte;
                            2'h1:    s_d.tl  = cmd_byte;
                            default: s_d.res = cmd_byte[CFG_RES_LSB +: 2];
                        endcase
                    end
                    if (s_q.idx == 7'(WR_SP_BITS - 1)) begin
                        s_d.st = S_HALT;
                    end
                end
            end
            // scratchpad out, byte 0 to crc
            S_READ_SP: begin
                if (RD_SLOT && s_q.idx != 7'(SP_BITS)) begin
                    s_d.idx = s_q.idx + 7'h1;
                end
            end
            default: begin
            end
        endcase

        if (long_low) begin
            s_d.st  = S_IDLE;
            s_d.idx = '0;
            s_d.sub = '0;
        end
        // reset and presence open a transaction
        // also ends any read in progress
        if (SLOT_RESET) begin
            s_d.st  = S_ROM_CMD;
            s_d.idx = '0;
            s_d.sub = '0;
        end

        // released line (1) unless in a sending phase
        case (s_d.st)
            S_READ_ID: s_d.rd_bit = ROM_ID[s_d.idx[5:0]];
            S_SEARCH: begin
                case (s_d.sub)
                    2'h0:    s_d.rd_bit = ROM_ID[s_d.idx[5:0]];
                    2'h1:    s_d.rd_bit = ~ROM_ID[s_d.idx[5:0]];
                    default: s_d.rd_bit = 1'b1;
                endcase
            end
            S_READ_SP: begin
                if (s_d.idx < 7'(SP_BITS)) begin
                    s_d.rd_bit = sp_next[s_d.idx];
                end else begin
                    s_d.rd_bit = 1'b1;
                end
            end
            // 0 while reloading, 1 when done
            S_RELOAD_STAT: s_d.rd_bit = ~s_d.reload_busy;
            default:       s_d.rd_bit = 1'b1;
        endcase
        s_d.busy = s_d.conv_busy | s_d.copy_busy | s_d.reload_busy;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s_q <= ST_RST;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign RD_BIT        = s_q.rd_bit;
    assign CONV_START    = s_q.conv_start;
    assign CONV_RES      = s_q.res;
    assign NV_COPY_REQ   = s_q.copy_req;
    assign NV_WR_DATA    = '{th: s_q.th, tl: s_q.tl, res: s_q.res};
    assign NV_RELOAD_REQ = s_q.reload_req;
    assign BUSY          = s_q.busy;
endmodule

// [verification/sensor_cmd_layer_properties.sv]
// port-level assertions for the sensor command layer
module sensor_cmd_checker (
    input wire logic                      MCLK,
    input wire logic                      RST_B,
    input wire logic                      CE,
    input wire logic                      DQ_IN,
    input wire logic                      SLOT_RESET,
    input wire logic                      WR_BIT_VLD,
    input wire logic                      RD_SLOT,
    input wire logic                      RD_BIT,
    input wire logic                      CONV_START,
    input wire logic [1:0]                CONV_RES,
    input wire logic                      CONV_DONE,
    input wire logic                      NV_COPY_REQ,
    input wire sensor_cmd_pkg::nv_bytes_t NV_WR_DATA,
    input wire logic                      NV_COPY_DONE,
    input wire logic                      NV_RELOAD_REQ,
    input wire logic                      NV_RELOAD_DONE,
    input wire logic                      BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_cmd_pkg::*;
    logic done_any;
    logic slot_any;
    logic res_cause;
    assign res_cause = CE & (WR_BIT_VLD | NV_RELOAD_DONE);
    assign done_any = CONV_DONE | NV_COPY_DONE | NV_RELOAD_DONE;
    assign slot_any = CE & (RD_SLOT | WR_BIT_VLD | SLOT_RESET | NV_RELOAD_DONE);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);
    sequence reload_go;
        NV_RELOAD_REQ && BUSY;
    endsequence
    chk_powerup_reload:
        assert property ($rose(RST_B) && CE |-> ##[1:2] reload_go)
        else $error("no reload after reset");
    chk_reset_idle:
        assert property ($rose(RST_B) |-> RD_BIT && !BUSY && CONV_RES == RES_RST)
        else $error("outputs not idle after reset");
    chk_start_pulse:
        assert property (CONV_START && CE |-> BUSY ##1 !CONV_START)
        else $error("conversion start not a busy pulse");
    chk_busy_drop:
        assert property (BUSY && CE && done_any && !CONV_START |=> !BUSY)
        else $error("busy held after done");
    chk_copy_data:
        assert property (NV_COPY_REQ && CE |->
            BUSY ##1 !NV_COPY_REQ && $stable(NV_WR_DATA))
        else $error("copy request data or pulse wrong");
    chk_reload_stat:
        assert property (NV_RELOAD_DONE && CE |=> RD_BIT && !BUSY)
        else $error("reload status not one after done");
    chk_rd_cause:
        assert property ($changed(RD_BIT) && $past(DQ_IN, 4) |-> $past(slot_any))
        else $error("read bit changed without a slot");
    chk_res_level:
        assert property ($changed(CONV_RES) |-> $past(res_cause))
        else $error("resolution changed without a cause");
endmodule

bind sensor_cmd_layer sensor_cmd_checker u_chk (
    .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .DQ_IN(DQ_IN),
    .SLOT_RESET(SLOT_RESET), .WR_BIT_VLD(WR_BIT_VLD), .RD_SLOT(RD_SLOT),
    .RD_BIT(RD_BIT), .CONV_START(CONV_START), .CONV_RES(CONV_RES),
    .CONV_DONE(CONV_DONE), .NV_COPY_REQ(NV_COPY_REQ),
    .NV_WR_DATA(NV_WR_DATA), .NV_COPY_DONE(NV_COPY_DONE),
    .NV_RELOAD_REQ(NV_RELOAD_REQ), .NV_RELOAD_DONE(NV_RELOAD_DONE),
    .BUSY(BUSY)
);

// [verification/sensor_backend_model.sv]
// converter and nonvolatile storage stand-in behind the command layer
module sensor_backend_model #(
    parameter int                        DLY     = 12,
    parameter sensor_cmd_pkg::nv_bytes_t NV_INIT = '0
) (
    input  wire logic                         clk,
    input  wire logic                         conv_start,
    input  wire logic                         copy_req,
    input  wire logic                         reload_req,
    input  wire sensor_cmd_pkg::nv_bytes_t    wr_data,
    input  wire sensor_cmd_pkg::conv_result_t result_in,
    output logic                              conv_done,
    output sensor_cmd_pkg::conv_result_t      conv_result,
    output logic                              copy_done,
    output logic                              reload_done,
    output sensor_cmd_pkg::nv_bytes_t         rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_cmd_pkg::*;
    int        cc = 0;
    int        kc = 0;
    int        rc = 0;
    nv_bytes_t nv = NV_INIT;
    always @(posedge clk) begin
        cc <= conv_start ? DLY : (cc > 0 ? cc - 1 : 0);
        kc <= copy_req ? DLY : (kc > 0 ? kc - 1 : 0);
        rc <= reload_req ? DLY : (rc > 0 ? rc - 1 : 0);
        if (copy_req)
            nv <= wr_data;
    end
    assign conv_done   = cc == 1;
    assign copy_done   = kc == 1;
    assign reload_done = rc == 1;
    assign conv_result = conv_done ? result_in : ~result_in;
    assign rd_data     = reload_done ? nv : ~nv;
endmodule

// [verification/sensor_cmd_layer_bench.sv]
// self-checking bench for the sensor command layer
module sensor_cmd_layer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_cmd_pkg::*;
    localparam int          LOW = 50;
    // arbitrary identity value
    localparam logic [63:0] ID  = 64'h3c00_0000_9a51_6e0d;
    localparam nv_bytes_t   NV0 = {8'h5a, 8'h11, 2'h1};
    localparam logic [15:0] TMP = 16'h0191;
    logic         mclk = 0;
    logic         rst_b = 0;
    logic         dq = 1;
    logic         srst = 0;
    logic         wv = 0;
    logic         wb = 0;
    logic         rs = 0;
    logic         ce = 1;
    logic         alm = 1;
    logic         rd_bit, c_start, c_done, cp_req, cp_done;
    logic         rl_req, rl_done, busy;
    logic [1:0]   c_res;
    conv_result_t c_out;
    nv_bytes_t    nv_wr, nv_rd;
    int           n_errors = 0;
    int           samples_checked = 0;
    int           cyc = 0;

    always #2 mclk = ~mclk;

    sensor_cmd_layer #(.LINE_LOW_CYC(LOW)) u_dut (
        .MCLK(mclk), .RST_B(rst_b), .CE(ce), .DQ_IN(dq),
        .SLOT_RESET(srst), .WR_BIT_VLD(wv), .WR_BIT(wb), .RD_SLOT(rs),
        .RD_BIT(rd_bit), .ROM_ID(ID), .CONV_START(c_start),
        .CONV_RES(c_res), .CONV_DONE(c_done), .CONV_RESULT(c_out),
        .NV_COPY_REQ(cp_req), .NV_WR_DATA(nv_wr), .NV_COPY_DONE(cp_done),
        .NV_RELOAD_REQ(rl_req), .NV_RELOAD_DONE(rl_done),
        .NV_RD_DATA(nv_rd), .BUSY(busy)
    );
    sensor_backend_model #(.NV_INIT(NV0)) u_far (
        .clk(mclk), .conv_start(c_start), .copy_req(cp_req),
        .reload_req(rl_req), .wr_data(nv_wr), .result_in({TMP, alm}),
        .conv_done(c_done), .conv_result(c_out), .copy_done(cp_done),
        .reload_done(rl_done), .rd_data(nv_rd)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [71:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic init;
        @(posedge mclk);
        srst <= 1;
        @(posedge mclk);
        srst <= 0;
    endtask
    task automatic wr_bit(input logic b);
        @(posedge mclk);
        wv <= 1;
        wb <= b;
        @(posedge mclk);
        wv <= 0;
    endtask
    task automatic wr_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            wr_bit(b[i]);
    endtask
    // bit i of v holds the i-th bit read; unread bits stay one
    task automatic rd_bits(input int n, output logic [71:0] v);
        v = '1;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            v[i] = rd_bit;
            rs <= 1;
            @(posedge mclk);
            rs <= 0;
            @(posedge mclk);
        end
    endtask
    task automatic sel(input logic [7:0] fc);
        init();
        wr_byte(CMD_SKIP_ID);
        wr_byte(fc);
    endtask
    task automatic settle;
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            tick(1);
        chk("busy", 72'(0), 72'(busy));
    endtask
    function automatic logic [7:0] crc(input logic [63:0] d);
        logic [7:0] c = 8'h00;
        for (int i = 0; i < 64; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY_REFL : 8'h00);
        return c;
    endfunction

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        logic [71:0] v;
        logic [63:0] sp;
        repeat (5) @(posedge mclk);
        rst_b <= 1;
        tick(30);
        chk("res", 72'(NV0.res), 72'(c_res));
        init();
        wr_byte(CMD_READ_ID);
        rd_bits(64, v);
        chk("id", {8'hff, ID}, v);
        $display("test read id finished");
        sel(CMD_WRITE_SP);
        wr_byte(8'h7e);
        wr_byte(8'h81);
        wr_byte(8'h5f);
        tick(2);
        chk("res", 72'(2'h2), 72'(c_res));
        sel(CMD_CONVERT);
        @(posedge mclk);
        chk("start", 72'(2'b11), 72'({c_start, busy}));
        settle();
        sel(CMD_READ_SP);
        rd_bits(72, v);
        sp = {24'hffffff, 8'h5f, 8'h81, 8'h7e, TMP};
        chk("scratchpad", {crc(sp), sp}, v);
        rd_bits(1, v);
        chk("past crc", '1, v);
        $display("test scratchpad finished");
        sel(CMD_READ_SP);
        rd_bits(12, v);
        chk("partial", {{60{1'b1}}, sp[11:0]}, v);
        init();
        wr_byte(CMD_READ_ID);
        rd_bits(4, v);
        chk("id head", {{68{1'b1}}, ID[3:0]}, v);
        dq <= 0;
        tick(LOW + 10);
        dq <= 1;
        rd_bits(8, v);
        chk("long low", '1, v);
        wr_byte(CMD_READ_ID);
        rd_bits(8, v);
        chk("no init", '1, v);
        $display("test abort finished");
        for (int k = 0; k < 2; k++) begin
            init();
            wr_byte(CMD_MATCH_ID);
            for (int i = 0; i < 64; i++)
                wr_bit(ID[i] ^ (i == 5 && k == 0));
            wr_byte(CMD_READ_SP);
            rd_bits(16, v);
            chk("match", k ? {{56{1'b1}}, TMP} : '1, v);
        end
        init();
        wr_byte(8'h00);
        wr_byte(CMD_READ_SP);
        rd_bits(8, v);
        chk("unknown", '1, v);
        $display("test selection finished");
        sel(CMD_COPY_SP);
        @(posedge mclk);
        chk("copy", 72'({3'h1, 8'h7e, 8'h81, 2'h2}), 72'({cp_req, nv_wr}));
        settle();
        sel(CMD_WRITE_SP);
        wr_byte(8'h01);
        wr_byte(8'h02);
        wr_byte(8'h1f);
        sel(CMD_RELOAD);
        @(posedge mclk);
        chk("reload req", 72'(2'b11), 72'({rl_req, busy}));
        rd_bits(1, v);
        chk("reload run", {{71{1'b1}}, 1'b0}, v);
        settle();
        rd_bits(1, v);
        chk("reload end", '1, v);
        chk("res", 72'(2'h2), 72'(c_res));
        $display("test storage finished");
        init();
        wr_byte(CMD_SEARCH_ID);
        for (int i = 0; i < 64; i++) begin
            rd_bits(2, v);
            chk("search", {{70{1'b1}}, ~ID[i], ID[i]}, v);
            wr_bit(ID[i]);
        end
        wr_byte(CMD_READ_SP);
        rd_bits(8, v);
        chk("after search", '1, v);
        init();
        wr_byte(CMD_ALARM_SRCH);
        rd_bits(2, v);
        chk("alarm", {{70{1'b1}}, ~ID[0], ID[0]}, v);
        wr_bit(~ID[0]);
        rd_bits(2, v);
        chk("dropped", '1, v);
        alm <= 0;
        sel(CMD_CONVERT);
        settle();
        init();
        wr_byte(CMD_ALARM_SRCH);
        rd_bits(2, v);
        chk("no alarm", '1, v);
        ce <= 0;
        init();
        wr_byte(CMD_READ_ID);
        ce <= 1;
        rd_bits(8, v);
        chk("frozen", '1, v);
        $display("test search finished");
        close_out();
    end
endmodule
